// ---- diphase_pkg.sv ----
// Shared constants for the diphase coax modem
package diphase_pkg;

    localparam longint CLK_HZ          = 64'd25_000_000;
    localparam longint NS_PER_SEC      = 64'd1_000_000_000;

    // Supported line rates in bits per second
    localparam int     RATE_1M         = 1_000_000;
    localparam int     RATE_500K       = 500_000;
    localparam int     RATE_250K       = 250_000;
    localparam int     RATE_56K        = 56_000;

    // Receiver timings as printed for the 1M rate, scaled for others
    localparam longint REF_BIT_NS      = 64'd1000;
    localparam longint EDGE_PULSE_NS   = 64'd200;
    localparam longint WINDOW_NS       = 64'd750;
    localparam longint STROBE_NS       = 64'd250;
    localparam longint LOSS_NS         = 64'd1500;

    // Transmit handshake, counted in bit times
    localparam logic [3:0] CTS_DELAY_BITS = 4'h7;
    localparam logic [3:0] TX_START_BITS  = 4'h3;

    // Power-up mark hold
    localparam longint POWERUP_HOLD_NS = 64'd4_000_000;
    localparam int     POWERUP_HOLD_CYCLES =
        int'(POWERUP_HOLD_NS * CLK_HZ / NS_PER_SEC);
    localparam int     HOLD_W          = 24;

    localparam logic   MARK_LEVEL      = 1'b1;
    localparam logic   MARK_BIT        = 1'b1;
    localparam int     TIMER_W         = 16;

    // Bit-time scaled duration in sys_clk cycles, never below one
    function automatic int scaled_cycles(input longint ref_ns,
                                         input longint bit_rate,
                                         input bit     round_up);
        longint num;
        longint den;
        longint q;
        num = ref_ns * CLK_HZ;
        den = REF_BIT_NS * bit_rate;
        q   = num / den;
        if (round_up && (q * den != num))
            q = q + 64'd1;
        if (q < 64'd1)
            q = 64'd1;
        return int'(q);
    endfunction

endpackage

// ---- pulse_timer.sv ----
// Counter-based one-shot, retriggerable or not
`timescale 1ns/1ns
module pulse_timer
    import diphase_pkg::*;
#(
    parameter int W      = TIMER_W,
    parameter int CYCLES = 5,
    parameter bit RETRIG = 1'b0
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic trigger,
    output logic      active
);

    logic [W-1:0] count;
    wire          load = trigger && (RETRIG || !active);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count  <= '0;
            active <= 1'b0;
        end
        else if (load)
        begin
            count  <= W'(CYCLES - 1);
            active <= 1'b1;
        end
        else if (active)
        begin
            if (count == '0)
                active <= 1'b0;
            else
                count <= count - W'(1);
        end
    end

endmodule

// ---- diphase_coax_modem.sv ----
// Diphase coax modem: line encoder, send handshake and bit recovery
//
// Functional notes
// - A space is two transitions per bit, a mark is one.
// - Timing source runs at twice the bit rate, halved to a square wave.
// - Output flip-flop toggles on each gating pulse: one per 1, two per 0.
// - Serial data is registered at the bit rate before the gating.
// - Line holds mark until send request and clear-to-send are both set.
// - Clear-to-send goes low seven bit times after send request.
// - Data starts three bit times after clear-to-send.
// - Line-enable sets after send request; only then line follows toggling.
// - After power-up the line is held at mark for several milliseconds.
// - Each rising edge of either detector gives a fixed 200 ns pulse.
// - Combined pulses start a non-retriggerable 750 ns clock window.
// - Window and pulses produce a data level held one full bit.
// - Receive clock is 250 ns pulses starting at each bit start.
// - Retriggerable 1.5 us timer clears receive data when clock is lost.
// - Bit rates 1M and 56K, also 250K and 500K, by scaled timings.
// - Clear-to-send is inverted to raise the transmit permit.
`timescale 1ns/1ns
module diphase_coax_modem
    import diphase_pkg::*;
#(
    parameter int BIT_RATE     = RATE_1M,
    parameter int POWERUP_HOLD = POWERUP_HOLD_CYCLES
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic tx_serial_bit_n,
    input  wire logic send_request_line,
    input  wire logic rx_line_pos,
    input  wire logic rx_line_neg,
    output logic      line_tx,
    output logic      line_clear_n,
    output logic      tx_permit,
    output logic      tx_bit_tick,
    output logic      rx_bit_level,
    output logic      rx_bit_strobe,
    output logic      rx_clock_lost
);

    // Receiver durations at this rate
    localparam int EDGE_CYC   = scaled_cycles(EDGE_PULSE_NS, BIT_RATE, 1'b1);
    localparam int WINDOW_CYC = scaled_cycles(WINDOW_NS, BIT_RATE, 1'b0);
    localparam int STROBE_CYC = scaled_cycles(STROBE_NS, BIT_RATE, 1'b1);
    localparam int LOSS_CYC   = scaled_cycles(LOSS_NS, BIT_RATE, 1'b0);

    // Accumulator step for the double-rate timing source
    localparam logic [31:0] NCO_STEP = 32'(2 * longint'(BIT_RATE));
    localparam logic [31:0] NCO_MOD  = 32'(CLK_HZ);

    typedef enum {
        TX_IDLE,
        TX_WAIT_CTS,
        TX_WAIT_DATA,
        TX_SEND
    } tx_phase_t;

    // Transmit timing
    logic [31:0]       nco_acc;
    logic              half;
    logic              data_ff;
    logic              out_ff;
    logic              send_request_ff;
    logic              enable_ff;
    logic [3:0]        bit_count;
    tx_phase_t         phase;
    tx_phase_t         next_phase;
    logic [HOLD_W-1:0] hold_count;
    logic              powerup_done;

    // Receive path
    logic [1:0]        rx_meta;
    logic [1:0]        rx_sync;
    logic [1:0]        rx_prev;
    logic [1:0]        edge_active;
    logic              pulse_prev;
    logic              window_active;
    logic              window_prev;
    logic              loss_active;
    logic              loss_prev;
    logic              saw_mid;

    wire [32:0] nco_sum      = {1'b0, nco_acc} + {1'b0, NCO_STEP};
    wire        dbl_tick     = nco_sum >= {1'b0, NCO_MOD};
    wire [31:0] next_acc     = dbl_tick ? 32'(nco_sum - {1'b0, NCO_MOD})
                                        : nco_sum[31:0];
    wire        bit_start    = dbl_tick && !half;
    wire        mid_tick     = dbl_tick && half;
    wire        gate_pulse   = bit_start || (mid_tick && !data_ff);
    wire        cts_on       = (phase == TX_WAIT_DATA) || (phase == TX_SEND);
    wire        line_go      = enable_ff && cts_on;
    wire        drive_line   = line_go && powerup_done;
    wire        count_done_c = bit_count == CTS_DELAY_BITS - 4'h1;
    wire        count_done_d = bit_count == TX_START_BITS - 4'h1;

    wire [1:0]  rx_rise      = rx_sync & ~rx_prev;
    wire        pulse_any    = |edge_active;
    wire        pulse_rise   = pulse_any && !pulse_prev;
    wire        window_start = pulse_rise && !window_active;
    wire        mid_hit      = pulse_rise && window_active;
    wire        window_end   = window_prev && !window_active;
    wire        loss_expire  = loss_prev && !loss_active;

    // Fractional divider gives the double-rate tick; 25 MHz is not an
    // integer multiple of every rate, so ticks jitter by one cycle.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            nco_acc <= 32'h0;
            half    <= 1'b0;
        end
        else
        begin
            nco_acc <= next_acc;
            if (dbl_tick)
                half <= !half;
        end
    end

    // Serial data register at the bit rate; marks fill until data starts
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            data_ff <= MARK_BIT;
        else if (bit_start)
        begin
            if (next_phase == TX_SEND)
                data_ff <= !tx_serial_bit_n;
            else
                data_ff <= MARK_BIT;
        end
    end

    // Output flip-flop toggles on every gating pulse while line_go is set, else holds mark
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            out_ff <= MARK_LEVEL;
        else if (!line_go)
            out_ff <= MARK_LEVEL;
        else if (gate_pulse)
            out_ff <= !out_ff;
    end

    // Send request and line enable
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            send_request_ff <= 1'b0;
            enable_ff       <= 1'b0;
        end
        else
        begin
            send_request_ff <= send_request_line;
            enable_ff       <= send_request_ff;
        end
    end

    always_comb
    begin
        next_phase = phase;
        case (phase)
            TX_IDLE:
                if (send_request_ff)
                    next_phase = TX_WAIT_CTS;
            TX_WAIT_CTS:
                if (!send_request_ff)
                    next_phase = TX_IDLE;
                else if (bit_start && count_done_c)
                    next_phase = TX_WAIT_DATA;
            TX_WAIT_DATA:
                if (!send_request_ff)
                    next_phase = TX_IDLE;
                else if (bit_start && count_done_d)
                    next_phase = TX_SEND;
            TX_SEND:
                if (!send_request_ff)
                    next_phase = TX_IDLE;
            default:
                next_phase = TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            phase     <= TX_IDLE;
            bit_count <= 4'h0;
        end
        else
        begin
            phase <= next_phase;
            if (next_phase != phase)
                bit_count <= 4'h0;
            else if (bit_start)
                bit_count <= bit_count + 4'h1;
        end
    end

    // Handshake outputs; permit trails clear-to-send by one cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            line_clear_n <= 1'b1;
            tx_permit    <= 1'b0;
            tx_bit_tick  <= 1'b0;
        end
        else
        begin
            line_clear_n <= !cts_on;
            tx_permit    <= !line_clear_n;
            tx_bit_tick  <= bit_start && (next_phase == TX_SEND);
        end
    end

    // Power-up hold keeps spurious symbols off the cable
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hold_count   <= '0;
            powerup_done <= 1'b0;
        end
        else if (!powerup_done)
        begin
            if (hold_count == HOLD_W'(POWERUP_HOLD - 1))
                powerup_done <= 1'b1;
            else
                hold_count <= hold_count + HOLD_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            line_tx <= MARK_LEVEL;
        else if (drive_line)
            line_tx <= out_ff;
        else
            line_tx <= MARK_LEVEL;
    end

    // Detector inputs come off the cable, so each is synchronised
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_det
            always_ff @(posedge sys_clk or posedge rst)
            begin
                // Reset high, so a detector that idles high gives no edge
                if (rst)
                begin
                    rx_meta[i] <= 1'b1;
                    rx_sync[i] <= 1'b1;
                    rx_prev[i] <= 1'b1;
                end
                else
                begin
                    rx_meta[i] <= (i == 0) ? rx_line_pos : rx_line_neg;
                    rx_sync[i] <= rx_meta[i];
                    rx_prev[i] <= rx_sync[i];
                end
            end

            pulse_timer #(
                .CYCLES (EDGE_CYC),
                .RETRIG (1'b0)
            ) u_edge (
                .sys_clk (sys_clk),
                .rst     (rst),
                .trigger (rx_rise[i]),
                .active  (edge_active[i])
            );
        end
    endgenerate

    pulse_timer #(
        .CYCLES (WINDOW_CYC),
        .RETRIG (1'b0)
    ) u_window (
        .sys_clk (sys_clk),
        .rst     (rst),
        .trigger (pulse_rise),
        .active  (window_active)
    );

    pulse_timer #(
        .CYCLES (STROBE_CYC),
        .RETRIG (1'b0)
    ) u_strobe (
        .sys_clk (sys_clk),
        .rst     (rst),
        .trigger (window_start),
        .active  (rx_bit_strobe)
    );

    pulse_timer #(
        .CYCLES (LOSS_CYC),
        .RETRIG (1'b1)
    ) u_loss (
        .sys_clk (sys_clk),
        .rst     (rst),
        .trigger (window_start),
        .active  (loss_active)
    );

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_prev  <= 1'b0;
            window_prev <= 1'b0;
            loss_prev   <= 1'b0;
        end
        else
        begin
            pulse_prev  <= pulse_any;
            window_prev <= window_active;
            loss_prev   <= loss_active;
        end
    end

    // Bit value is known only at window end, so the level lags by one bit
    // and is stable across the next strobe.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            saw_mid       <= 1'b0;
            rx_bit_level  <= 1'b0;
            rx_clock_lost <= 1'b1;
        end
        else if (loss_expire)
        begin
            saw_mid       <= 1'b0;
            rx_bit_level  <= 1'b0;
            rx_clock_lost <= 1'b1;
        end
        else
        begin
            if (window_start)
            begin
                saw_mid       <= 1'b0;
                rx_clock_lost <= 1'b0;
            end
            else if (mid_hit)
                saw_mid <= 1'b1;
            if (window_end)
                rx_bit_level <= !saw_mid;
        end
    end

endmodule

// ---- remote_line_unit.sv ----
// Remote station model: diphase sender toward the modem receiver
`timescale 1ns/1ns
module remote_line_unit
(
    input  wire logic        sys_clk,
    input  wire logic        go,
    input  wire logic [15:0] word,
    input  wire logic        slow,
    output logic             rx_line_pos,
    output logic             rx_line_neg
);
    logic level;
    int   half;

    // Line holds its level between frames, so the receiver sees silence
    initial
    begin
        level = 1'b0;
        half  = 13;
        forever
        begin
            @(negedge sys_clk);
            if (go)
            begin
                half = slow ? 16 : 13;
                for (int i = 15; i >= 0; i--)
                begin
                    level = !level;
                    repeat (half) @(negedge sys_clk);
                    if (!word[i])
                        level = !level;
                    repeat (half) @(negedge sys_clk);
                end
            end
        end
    end

    assign rx_line_pos = level;
    assign rx_line_neg = !level;
endmodule

// ---- modem_monitor.sv ----
// Concurrent checks on the modem ports
`timescale 1ns/1ns
module modem_monitor
    import diphase_pkg::*;
#(
    parameter int BIT_RATE     = RATE_1M,
    parameter int POWERUP_HOLD = POWERUP_HOLD_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tx_serial_bit_n,
    input wire logic send_request_line,
    input wire logic rx_line_pos,
    input wire logic rx_line_neg,
    input wire logic line_tx,
    input wire logic line_clear_n,
    input wire logic tx_permit,
    input wire logic tx_bit_tick,
    input wire logic rx_bit_level,
    input wire logic rx_bit_strobe,
    input wire logic rx_clock_lost
);
    // Figures below hold for the 1M rate only
    int since_rst;
    int since_req;
    int since_strobe;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            since_rst    <= 0;
            since_req    <= 0;
            since_strobe <= 0;
        end
        else
        begin
            since_rst    <= since_rst + 1;
            since_req    <= send_request_line ? since_req + 1 : 0;
            since_strobe <= rx_bit_strobe ? 0 : since_strobe + 1;
        end
    end

    sequence s_req_gone;
        !send_request_line [*4];
    endsequence
    sequence s_strobe_pulse;
        rx_bit_strobe [*7] ##1 !rx_bit_strobe;
    endsequence

    a_powerup_mark: assert property (
        since_rst < POWERUP_HOLD |-> line_tx)
        else $error("line left mark in power-up hold");
    a_idle_mark_hold: assert property (
        s_req_gone |-> line_tx && line_clear_n)
        else $error("line not in mark hold without request");
    a_cts_delay: assert property (
        $fell(line_clear_n) |-> since_req inside {[150:182]})
        else $error("clear to send at wrong delay");
    a_send_start: assert property (
        $fell(line_clear_n) |-> ##[74:76] tx_bit_tick)
        else $error("first data bit not three bits after clear");
    a_tick_in_send: assert property (
        tx_bit_tick |-> !line_clear_n && tx_permit)
        else $error("data taken outside send phase");
    a_permit_invert: assert property (
        $fell(line_clear_n) |=> tx_permit)
        else $error("permit did not follow clear to send");
    a_strobe_width: assert property (
        $rose(rx_bit_strobe) |-> s_strobe_pulse)
        else $error("receive strobe width wrong");
    a_level_steady: assert property (
        rx_bit_strobe |-> $stable(rx_bit_level))
        else $error("receive level moved at bit start");
    a_loss_clears: assert property (
        $rose(rx_clock_lost) |->
        !rx_bit_level && since_strobe inside {[25:40]})
        else $error("clock loss at wrong time or data not cleared");
endmodule

bind diphase_coax_modem modem_monitor #(
    .BIT_RATE(BIT_RATE),
    .POWERUP_HOLD(POWERUP_HOLD)
) chk (.sys_clk, .rst, .tx_serial_bit_n, .send_request_line, .rx_line_pos,
    .rx_line_neg, .line_tx, .line_clear_n, .tx_permit, .tx_bit_tick,
    .rx_bit_level, .rx_bit_strobe, .rx_clock_lost);

// ---- tb_top.sv ----
// Self-checking bench for the diphase coax modem
`timescale 1ns/1ns
module tb_top
    import diphase_pkg::*;
;
    localparam int HOLD = 300;
    logic        sys_clk;
    logic        rst;
    logic        tx_serial_bit_n;
    logic        send_request_line;
    logic        rx_line_pos;
    logic        rx_line_neg;
    logic        line_tx;
    logic        line_clear_n;
    logic        tx_permit;
    logic        tx_bit_tick;
    logic        rx_bit_level;
    logic        rx_bit_strobe;
    logic        rx_clock_lost;
    logic        go;
    logic        slow;
    logic [15:0] word;
    logic [31:0] seed;
    int          err_total;
    int          check_count;

    diphase_coax_modem #(.BIT_RATE(RATE_1M), .POWERUP_HOLD(HOLD)) uut (
        .sys_clk, .rst, .tx_serial_bit_n, .send_request_line, .rx_line_pos,
        .rx_line_neg, .line_tx, .line_clear_n, .tx_permit, .tx_bit_tick,
        .rx_bit_level, .rx_bit_strobe, .rx_clock_lost);
    remote_line_unit peer (.sys_clk, .go, .word, .slow, .rx_line_pos,
        .rx_line_neg);

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic stall_out(input string what);
        err_total++;
        $display("[ERR] %0t wait ran out: %s", $time, what);
        print_verdict();
    endtask

    // Window of 25 samples always holds exactly one bit-start transition
    task automatic tx_session(input int nbits);
        int   n;
        int   edges;
        logic cur;
        logic prev;
        send_request_line = 1'b1;
        n = 0;
        while (line_clear_n !== 1'b0 && n < 300)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 300)
            stall_out("clear to send");
        check(n >= 150 && n <= 182, 1'b1, "cts delay");
        @(negedge sys_clk);
        check(tx_permit, 1'b1, "permit");
        n = 0;
        while (tx_bit_tick !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 100)
            stall_out("first bit");
        check(n >= 70 && n <= 78, 1'b1, "send start");
        for (int b = 0; b < nbits; b++)
        begin
            cur = tx_serial_bit_n;
            seed = xorshift(seed);
            tx_serial_bit_n = seed[0];
            prev = line_tx;
            edges = 0;
            repeat (25)
            begin
                @(negedge sys_clk);
                edges += (line_tx !== prev);
                prev = line_tx;
            end
            check(edges, cur ? 2 : 1, "tx edges");
            check(tx_bit_tick, 1'b1, "bit tick");
        end
        send_request_line = 1'b0;
        repeat (4) @(negedge sys_clk);
        check({line_tx, line_clear_n}, {MARK_LEVEL, 1'b1}, "idle");
    endtask

    // The strobe of bit k shows the level decoded for bit k-1
    task automatic rx_frame(input logic [15:0] w, input logic s);
        int   n;
        logic prev;
        word = w;
        slow = s;
        go <= 1'b1;
        @(negedge sys_clk);
        go <= 1'b0;
        for (int k = 0; k < 16; k++)
        begin
            n = 0;
            prev = 1'b1;
            while (!(rx_bit_strobe === 1'b1 && !prev) && n < 60)
            begin
                prev = rx_bit_strobe;
                @(negedge sys_clk);
                n++;
            end
            if (n >= 60)
                stall_out("receive strobe");
            if (k > 0)
                check(rx_bit_level, w[16 - k], "rx bit");
        end
        repeat (28) @(negedge sys_clk);
        check(rx_bit_level, w[0], "rx last bit");
        repeat (20) @(negedge sys_clk);
        check({rx_clock_lost, rx_bit_level}, 2'b10, "clock loss");
    endtask

    initial
    begin
        rst = 1'b1;
        tx_serial_bit_n = 1'b0;
        send_request_line = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        word = 16'h0000;
        seed = 32'hcac2;
        err_total = 0;
        check_count = 0;
        repeat (10) @(negedge sys_clk);
        check({line_tx, line_clear_n, tx_permit, rx_clock_lost}, 4'hd,
              "reset");
        rst = 1'b0;
        // Clear to send and first data bit come while the hold still runs,
        // so the toggling output must stay off the line
        send_request_line = 1'b1;
        repeat (200) @(negedge sys_clk);
        check(line_clear_n, 1'b0, "cts in hold");
        repeat (70)
        begin
            @(negedge sys_clk);
            check(line_tx, MARK_LEVEL, "power-up hold");
        end
        send_request_line = 1'b0;
        repeat (4) @(negedge sys_clk);
        tx_session(12);
        tx_session(3);
        for (int i = 0; i < 4; i++)
        begin
            seed = xorshift(seed);
            rx_frame(i == 0 ? 16'h0000 : i == 1 ? 16'hffff : seed[15:0],
                     i == 3);
        end
        print_verdict();
    end
endmodule
